// >>> obtr_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Far-side party of one bus: drives its value, yields when the device drives
// ****
module obtr_bus_partner (
	input wire logic [obtr_pkg::DATA_W-1:0] val,
	input wire logic [obtr_pkg::DATA_W-1:0] o,
	input wire logic [obtr_pkg::DATA_W-1:0] oe_n,
	output logic [obtr_pkg::DATA_W-1:0] line
);
	always_comb begin
		for (int i = 0; i < obtr_pkg::DATA_W; i++) begin
			line[i] = oe_n[i] ? val[i] : o[i];
		end
	end
endmodule : obtr_bus_partner
`default_nettype wire

// >>> obtr_pkg.sv
package obtr_pkg;

	// ****************************************************************
	// Widths and encodings
	// ****************************************************************
	localparam int unsigned DATA_W = 8;
	localparam logic DIR_B_TO_A = 1'b0;
	localparam logic DIR_A_TO_B = 1'b1;
	localparam logic SEL_LIVE = 1'b0;
	localparam logic SEL_STORED = 1'b1;
	localparam logic OE_N_ON = 1'b0;
	// Pin enables are active low: high means released
	localparam logic [DATA_W-1:0] PIN_RELEASED = 8'hff;
	localparam logic [DATA_W-1:0] PIN_DRIVEN = 8'h00;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] o;
		logic [DATA_W-1:0] oe_n;
	} obtr_pin_drv_t;

	typedef struct packed {
		logic oe_n;
		logic dir;
		logic a_to_b_source_select;
		logic b_to_a_source_select;
	} obtr_ctl_t;

endpackage : obtr_pkg

// >>> obtr_transceiver.sv
`timescale 1ns/1ps
`default_nettype none

module obtr_transceiver #(
	parameter int unsigned DATA_W = obtr_pkg::DATA_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic a_side_capture_clock,
	input wire logic b_side_capture_clock,
	input wire logic a_to_b_source_select,
	input wire logic b_to_a_source_select,
	input wire logic oe_n,
	input wire logic dir,
	input wire logic [DATA_W-1:0] bus_a_i,
	output logic [DATA_W-1:0] bus_a_o,
	output logic [DATA_W-1:0] bus_a_oe_n,
	input wire logic [DATA_W-1:0] bus_b_i,
	output logic [DATA_W-1:0] bus_b_o,
	output logic [DATA_W-1:0] bus_b_oe_n
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// Every pin crosses two flops; stage one feeds only stage two
	localparam int unsigned SYN_W = 2 * DATA_W + 6;
	logic [SYN_W-1:0] syn1_q, syn1_d;
	logic [SYN_W-1:0] syn2_q, syn2_d;

	always_comb begin
		// Control bits follow the field order of the control carrier
		syn1_d = {bus_a_i, bus_b_i, a_side_capture_clock, b_side_capture_clock,
			oe_n, dir, a_to_b_source_select, b_to_a_source_select};
		syn2_d = syn1_q;
	end

	always_ff @(posedge ref_clk) begin
		syn1_q <= syn1_d;
		syn2_q <= syn2_d;
	end

	logic [DATA_W-1:0] a_live, b_live;
	logic clk_ab_s, clk_ba_s;
	obtr_pkg::obtr_ctl_t ctl;

	always_comb begin
		{a_live, b_live, clk_ab_s, clk_ba_s, ctl} = syn2_q;
	end

	// ****************************************************************
	// Capture edge detection
	// ****************************************************************
	logic clk_ab_prev_q, clk_ab_prev_d;
	logic clk_ba_prev_q, clk_ba_prev_d;
	logic cap_a, cap_b;

	always_comb begin
		clk_ab_prev_d = clk_ab_s;
		clk_ba_prev_d = clk_ba_s;
		cap_a = clk_ab_s & ~clk_ab_prev_q;
		cap_b = clk_ba_s & ~clk_ba_prev_q;
	end

	// Edge history resets high so a clock held high at release is no edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_ab_prev_q <= 1'b1;
			clk_ba_prev_q <= 1'b1;
		end else begin
			clk_ab_prev_q <= clk_ab_prev_d;
			clk_ba_prev_q <= clk_ba_prev_d;
		end
	end

	// ****************************************************************
	// Storage registers
	// ****************************************************************
	logic [DATA_W-1:0] store_a_q, store_a_d;
	logic [DATA_W-1:0] store_b_q, store_b_d;

	// Capture ignores enable and direction, so both may load together
	always_comb begin
		store_a_d = cap_a ? a_live : store_a_q;
		store_b_d = cap_b ? b_live : store_b_q;
	end

	// No reset term: contents stay unknown until the first capture
	always_ff @(posedge ref_clk) begin
		store_a_q <= store_a_d;
		store_b_q <= store_b_d;
	end

	// ****************************************************************
	// Output selection
	// ****************************************************************
	obtr_pkg::obtr_pin_drv_t drv_a_q, drv_a_d;
	obtr_pkg::obtr_pin_drv_t drv_b_q, drv_b_d;
	logic en_a, en_b;

	// Shared by both buses so the two enables can never disagree on decoding
	function automatic logic drive_enabled(
		input obtr_pkg::obtr_ctl_t c,
		input logic dir_code
	);
		return (c.oe_n == obtr_pkg::OE_N_ON) && (c.dir == dir_code);
	endfunction : drive_enabled

	// Drive depends only on enable and direction, never on capture
	always_comb begin
		en_a = drive_enabled(ctl, obtr_pkg::DIR_B_TO_A);
		en_b = drive_enabled(ctl, obtr_pkg::DIR_A_TO_B);
		drv_a_d.o = (ctl.b_to_a_source_select == obtr_pkg::SEL_STORED) ?
			store_b_q : b_live;
		drv_b_d.o = (ctl.a_to_b_source_select == obtr_pkg::SEL_STORED) ?
			store_a_q : a_live;
		drv_a_d.oe_n = en_a ? obtr_pkg::PIN_DRIVEN : obtr_pkg::PIN_RELEASED;
		drv_b_d.oe_n = en_b ? obtr_pkg::PIN_DRIVEN : obtr_pkg::PIN_RELEASED;
	end

	// Reset releases both buses; the data side of the driver is harmless
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drv_a_q.o <= '0;
			drv_b_q.o <= '0;
			drv_a_q.oe_n <= obtr_pkg::PIN_RELEASED;
			drv_b_q.oe_n <= obtr_pkg::PIN_RELEASED;
		end else begin
			drv_a_q <= drv_a_d;
			drv_b_q <= drv_b_d;
		end
	end

	always_comb begin
		bus_a_o = drv_a_q.o;
		bus_a_oe_n = drv_a_q.oe_n;
		bus_b_o = drv_b_q.o;
		bus_b_oe_n = drv_b_q.oe_n;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_never_both_driven: assert property (@(posedge ref_clk) disable iff (rst)
		!((bus_a_oe_n != obtr_pkg::PIN_RELEASED) && (bus_b_oe_n != obtr_pkg::PIN_RELEASED)))
		else $error("both buses driven");

	a_disabled_releases: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.oe_n != obtr_pkg::OE_N_ON) |=> (bus_a_oe_n == obtr_pkg::PIN_RELEASED)
			&& (bus_b_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus driven while disabled");

	a_dir_low_drives_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.oe_n == obtr_pkg::OE_N_ON && ctl.dir == obtr_pkg::DIR_B_TO_A) |=>
			(bus_a_oe_n == obtr_pkg::PIN_DRIVEN) && (bus_b_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("direction low did not drive bus a");

	a_dir_high_drives_b: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.oe_n == obtr_pkg::OE_N_ON && ctl.dir == obtr_pkg::DIR_A_TO_B) |=>
			(bus_b_oe_n == obtr_pkg::PIN_DRIVEN) && (bus_a_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("direction high did not drive bus b");

	a_capture_a_loads: assert property (@(posedge ref_clk) disable iff (rst)
		cap_a |=> (store_a_q == $past(a_live)))
		else $error("a-side register missed capture");

	a_capture_b_loads: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_b && ctl.oe_n != obtr_pkg::OE_N_ON) |=> (store_b_q == $past(b_live)))
		else $error("b-side register missed capture while disabled");

	a_hold_no_edge: assert property (@(posedge ref_clk) disable iff (rst)
		(!cap_a && !cap_b) |=> $stable(store_a_q) && $stable(store_b_q))
		else $error("register changed without capture edge");

	a_stored_to_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.b_to_a_source_select == obtr_pkg::SEL_STORED) |=> (bus_a_o == $past(store_b_q)))
		else $error("bus a not driven from stored b data");

	a_live_to_b: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.a_to_b_source_select == obtr_pkg::SEL_LIVE) |=> (bus_b_o == $past(a_live)))
		else $error("bus b not driven from live a data");

	a_stored_to_b: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.a_to_b_source_select == obtr_pkg::SEL_STORED) |=>
			(bus_b_o == $past(store_a_q)))
		else $error("bus b not driven from stored a data");

	a_live_to_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.b_to_a_source_select == obtr_pkg::SEL_LIVE) |=>
			(bus_a_o == $past(b_live)))
		else $error("bus a not driven from live b data");

	a_dir_low_frees_b: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.dir == obtr_pkg::DIR_B_TO_A) |=>
			(bus_b_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus b driven with direction low");

	a_dir_high_frees_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ctl.dir == obtr_pkg::DIR_A_TO_B) |=>
			(bus_a_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus a driven with direction high");

	a_lines_agree_a: assert property (@(posedge ref_clk) disable iff (rst)
		(bus_a_oe_n == obtr_pkg::PIN_DRIVEN) ||
			(bus_a_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus a lines disagree on drive");

	a_lines_agree_b: assert property (@(posedge ref_clk) disable iff (rst)
		(bus_b_oe_n == obtr_pkg::PIN_DRIVEN) ||
			(bus_b_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus b lines disagree on drive");

	// Drive must trace back to the controls, not to a capture
	a_b_needs_enable: assert property (@(posedge ref_clk) disable iff (rst)
		(bus_b_oe_n == obtr_pkg::PIN_DRIVEN) |->
			($past(ctl.oe_n) == obtr_pkg::OE_N_ON) &&
			($past(ctl.dir) == obtr_pkg::DIR_A_TO_B))
		else $error("bus b driven without enable");

	a_a_needs_enable: assert property (@(posedge ref_clk) disable iff (rst)
		(bus_a_oe_n == obtr_pkg::PIN_DRIVEN) |->
			($past(ctl.oe_n) == obtr_pkg::OE_N_ON) &&
			($past(ctl.dir) == obtr_pkg::DIR_B_TO_A))
		else $error("bus a driven without enable");

	// ****************************************************************
	// Capture assertions
	// ****************************************************************

	a_capture_b_any: assert property (@(posedge ref_clk) disable iff (rst)
		cap_b |=> (store_b_q == $past(b_live)))
		else $error("b-side register missed capture");

	a_capture_a_isolated: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_a && ctl.oe_n != obtr_pkg::OE_N_ON) |=> (store_a_q == $past(a_live)))
		else $error("a-side register missed capture while disabled");

	a_capture_both: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_a && cap_b) |=>
			(store_a_q == $past(a_live)) && (store_b_q == $past(b_live)))
		else $error("joint capture missed a register");

	// Checked per register so one capture cannot hide a stray load in the other
	a_hold_a_alone: assert property (@(posedge ref_clk) disable iff (rst)
		!cap_a |=> $stable(store_a_q))
		else $error("a-side register changed without its edge");

	a_hold_b_alone: assert property (@(posedge ref_clk) disable iff (rst)
		!cap_b |=> $stable(store_b_q))
		else $error("b-side register changed without its edge");

	a_capture_keeps_b: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_a && en_b) |=> (bus_b_oe_n == obtr_pkg::PIN_DRIVEN))
		else $error("a-side capture disturbed bus b drive");

	a_capture_keeps_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_b && en_a) |=> (bus_a_oe_n == obtr_pkg::PIN_DRIVEN))
		else $error("b-side capture disturbed bus a drive");

	a_capture_a_driving: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_a && en_b) |=> (store_a_q == $past(a_live)))
		else $error("a-side register missed capture while driving");

	a_capture_b_driving: assert property (@(posedge ref_clk) disable iff (rst)
		(cap_b && en_a) |=> (store_b_q == $past(b_live)))
		else $error("b-side register missed capture while driving");

	// ****************************************************************
	// Reset assertions
	// ****************************************************************

	a_reset_releases: assert property (@(posedge ref_clk)
		rst |=> (bus_a_oe_n == obtr_pkg::PIN_RELEASED) &&
			(bus_b_oe_n == obtr_pkg::PIN_RELEASED))
		else $error("bus driven after reset");

	a_reset_clears_data: assert property (@(posedge ref_clk)
		rst |=> (bus_a_o == '0) &&
			(bus_b_o == '0))
		else $error("driver data not cleared by reset");

	// A capture clock already high at release must not count as a rise
	a_no_edge_at_release: assert property (@(posedge ref_clk)
		$fell(rst) |-> !cap_a && !cap_b)
		else $error("capture seen at reset release");

endmodule : obtr_transceiver
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		fails++; \
		$display("BAD %0t mismatch", $time); \
	end \
end
module testbench;
	// ****
	// Stimulus, wires and instances
	// ****
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic a_side_capture_clock = 1'b0;
	logic b_side_capture_clock = 1'b0;
	obtr_pkg::obtr_ctl_t ctl_q = 4'h8;
	logic [7:0] a_val = 8'h00;
	logic [7:0] b_val = 8'h00;
	logic [7:0] a_o, a_oe_n, a_line, b_o, b_oe_n, b_line;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 ref_clk = ~ref_clk;
	obtr_transceiver i_dut (.ref_clk(ref_clk), .rst(rst),
		.a_side_capture_clock(a_side_capture_clock), .b_side_capture_clock(b_side_capture_clock),
		.a_to_b_source_select(ctl_q.a_to_b_source_select),
		.b_to_a_source_select(ctl_q.b_to_a_source_select), .oe_n(ctl_q.oe_n), .dir(ctl_q.dir),
		.bus_a_i(a_line), .bus_a_o(a_o), .bus_a_oe_n(a_oe_n),
		.bus_b_i(b_line), .bus_b_o(b_o), .bus_b_oe_n(b_oe_n));
	obtr_bus_partner i_far_a (.val(a_val), .o(a_o), .oe_n(a_oe_n), .line(a_line));
	obtr_bus_partner i_far_b (.val(b_val), .o(b_o), .oe_n(b_oe_n), .line(b_line));
	// ****
	// Tasks
	// ****
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : step
	// Seven edges: three to turn the far bus round, three for its value, one spare
	task automatic drive(input logic [3:0] c, input logic [7:0] av, input logic [7:0] bv);
		@(posedge ref_clk);
		ctl_q <= c;
		a_val <= av;
		b_val <= bv;
		step(7);
		#1;
	endtask : drive
	// Pulses held four cycles each side so the sampler cannot miss them
	task automatic pulse(input logic ca, input logic cb);
		@(posedge ref_clk);
		a_side_capture_clock <= ca;
		b_side_capture_clock <= cb;
		step(4);
		a_side_capture_clock <= 1'b0;
		b_side_capture_clock <= 1'b0;
		step(4);
		#1;
	endtask : pulse
	task automatic live_paths();
		drive(4'h4, 8'ha5, 8'h00);
		`CHK(b_o, 8'ha5)
		`CHK(b_oe_n, obtr_pkg::PIN_DRIVEN)
		`CHK(a_oe_n, obtr_pkg::PIN_RELEASED)
		drive(4'h0, 8'h00, 8'h3c);
		`CHK(a_o, 8'h3c)
		`CHK(a_oe_n, obtr_pkg::PIN_DRIVEN)
		`CHK(b_oe_n, obtr_pkg::PIN_RELEASED)
	endtask : live_paths
	task automatic isolate_store();
		drive(4'h8, 8'h81, 8'h42);
		`CHK(a_oe_n & b_oe_n, obtr_pkg::PIN_RELEASED)
		pulse(1'b1, 1'b1);
		drive(4'h6, 8'h00, 8'hff);
		`CHK(b_o, 8'h81)
		drive(4'h1, 8'h00, 8'hff);
		`CHK(a_o, 8'h42)
	endtask : isolate_store
	task automatic capture_while_driving();
		drive(4'h4, 8'h96, 8'h00);
		pulse(1'b1, 1'b0);
		`CHK(b_oe_n, obtr_pkg::PIN_DRIVEN)
		drive(4'h6, 8'h11, 8'h00);
		`CHK(b_o, 8'h96)
		drive(4'h4, 8'h11, 8'h00);
		`CHK(b_o, 8'h11)
		drive(4'h1, 8'h00, 8'h77);
		`CHK(a_o, 8'h42)
		pulse(1'b0, 1'b1);
		`CHK(a_oe_n, obtr_pkg::PIN_DRIVEN)
		`CHK(a_o, 8'h77)
	endtask : capture_while_driving
	task automatic conclude();
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	// Whole run is about 110 cycles; the ceiling of 2000 leaves ample margin
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			$display("BAD %0t timeout", $time);
			conclude();
		end
	end
	initial begin
		step(10);
		#1;
		`CHK(a_oe_n & b_oe_n, obtr_pkg::PIN_RELEASED)
		@(posedge ref_clk);
		rst <= 1'b0;
		step(2);
		live_paths();
		isolate_store();
		capture_while_driving();
		conclude();
	end
endmodule : testbench
`default_nettype wire
